// *** rtl/dcr_pkg.sv ***
// Constants, register map and carrier types of the working-register and address block.
// Overview of operation
// - Data path is 16 bits; instruction words are 24 bits with variable opcodes.
// - Program counter holds 23 bits, reaching 4M words of 24 bits.
// - Most instructions take one cycle; flow changes and table accesses may take more.
// - Block loops and repeats carry no per-pass overhead and stay interruptible.
// - Sixteen 16-bit working registers serve as data, pointer or offset.
// - Working register fifteen is the stack pointer for calls and interrupts.
// - Two alternate sets copy registers zero to fourteen and keep their contents.
// - Each alternate set is tied to one priority level one to six.
// - A swap command switches the active set to a chosen one by hand.
// - Two 3-bit fields show the active set and the last manually chosen set.
// - Base data space is 4K words, split into X and Y with own generators.
// - General instructions address only through the X generator, one linear space.
// - Some DSP instructions use X and Y together; the boundary is a constant.
// - Upper 32 Kbytes may map onto program space at any 16K-word boundary.
// - Base address plus read or write page forms an extended 24-bit address.
// - X and Y generators both wrap circular buffers in hardware.
// - The X generator also steps bit-reversed addresses for radix-2 transforms.
// - Six addressing modes exist; each instruction uses a predefined group of them.
// - All programmer's-model registers are memory mapped; all but loop start, the spare register and context status are writable by instructions.
// - Mapped registers zero to fourteen reach the currently active set.
// - Loop start registers are read only; writes to them do nothing.
// - General and DSP instructions share one execution unit.
// - Context code 000 is default, 001 set one, 010 set two; others reserved.
package dcr_pkg;
   localparam int DATA_W = 16;
   localparam int INSN_W = 24;
   localparam int PC_W = 23;
   localparam int EXT_W = 24;
   localparam int IDX_W = 6;
   localparam int NW = 15;
   // Word indices on the register bus; byte address is four times the index.
   localparam logic [5:0] IX_SP = 6'h0f;
   localparam logic [5:0] IX_SFR0 = 6'h10;
   localparam int SFR_N = 28;
   localparam int S_ACCUMULATOR_A_L = 0, S_ACCUMULATOR_A_H = 1, S_ACCUMULATOR_A_U = 2;
   localparam int S_ACCUMULATOR_B_L = 3, S_ACCUMULATOR_B_H = 4, S_ACCUMULATOR_B_U = 5;
   localparam int S_PC_L = 6, S_PC_H = 7, S_STATUS = 8, S_STK_LIM = 9;
   localparam int S_TBL_PAGE = 10, S_RD_PAGE = 11, S_WR_PAGE = 12;
   localparam int S_REP_CNT = 13, S_LOOP_CNT = 14;
   localparam int S_LSTART_L = 15, S_LSTART_H = 16, S_LEND_L = 17, S_LEND_H = 18;
   localparam int S_CORE_CTL = 19, S_ALT_CFG = 20;
   localparam int S_XMOD_ST = 21, S_XMOD_END = 22, S_YMOD_ST = 23, S_YMOD_END = 24;
   localparam int S_MOD_CTL = 25, S_BREV_CTL = 26, S_SPARE = 27;
   localparam logic [5:0] IX_CTX_STAT = 6'h2c;
   // Writable bits of each spare-function register, and reset values.
   localparam logic [15:0] SFR_MASK [SFR_N] = '{
      16'hffff, 16'hffff, 16'h00ff, 16'hffff, 16'hffff, 16'h00ff,
      16'hfffe, 16'h007f, 16'hffff, 16'hfffe, 16'h00ff, 16'h03ff, 16'h01ff,
      16'hffff, 16'hffff, 16'h0000, 16'h0000, 16'hfffe, 16'h003f,
      16'hb0f3, 16'h0077, 16'hfffe, 16'hfffe, 16'hfffe, 16'hfffe,
      16'hc0ff, 16'hffff, 16'h0000};
   localparam logic [15:0] CORE_CTL_RST = 16'h0020;
   // Field positions.
   localparam int ALT1_LSB = 0, ALT2_LSB = 4;
   localparam int MOD_XEN = 15, MOD_YEN = 14, MOD_YPTR_LSB = 4, MOD_XPTR_LSB = 0;
   localparam int BREV_EN = 15;
   localparam int PSV_BIT = 9;
   localparam int CTX_CUR_LSB = 8;
   localparam logic [2:0] LVL_MIN = 3'h1, LVL_MAX = 3'h6;
   typedef enum logic [2:0] {CTX_DEF = 3'h0, CTX_ALT1 = 3'h1, CTX_ALT2 = 3'h2} dcr_ctx_t;
   typedef struct packed {
      logic valid;
      logic y_gen;
      logic wr;
      logic [3:0] ptr;
      logic [15:0] off;
   } dcr_agu_req_t;
   typedef struct packed {
      logic valid;
      logic [5:0] idx;
      logic [15:0] data;
   } dcr_core_wr_t;
endpackage

// *** rtl/dcr_regfile.sv ***
// Working registers, context sets, mapped core registers and X/Y address generators.
//
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module dcr_regfile #(
   parameter logic [15:0] Y_BASE = 16'h1000
) (
   // Clock and reset.
   input wire logic CLK,
   input wire logic RST,
   // Avalon-MM register slave.
   input wire logic [5:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Core register access.
   input wire dcr_pkg::dcr_core_wr_t CORE_WR,
   input wire logic [3:0] RD_SEL,
   output logic [15:0] RD_DATA,
   // Interrupt and context control.
   input wire logic INT_TAKE,
   input wire logic INT_RETURN,
   input wire logic [2:0] INT_LEVEL,
   input wire logic SWAP_VALID,
   input wire logic [2:0] SWAP_CTX,
   output logic [2:0] CUR_CTX,
   // Loop hardware load.
   input wire logic LOOP_LOAD,
   input wire logic [22:0] LOOP_START,
   input wire logic [22:0] LOOP_END,
   input wire logic [15:0] LOOP_COUNT,
   // Address generation.
   input wire dcr_pkg::dcr_agu_req_t AG_REQ,
   output logic [23:0] AG_ADDR,
   output logic AG_PSV,
   output logic AG_YERR,
   output logic AG_DONE,
   output logic STK_ERR
);
   localparam int NBANK = 3 * dcr_pkg::NW;

   if (Y_BASE[0] != 1'b0 || Y_BASE > 16'h2000) begin : g_bad_ybase
      $error("Y_BASE must be even and inside the base data space");
   end
   // Port widths are written out above, so the package widths must agree with them.
   if (dcr_pkg::DATA_W != 16 || dcr_pkg::INSN_W != 24 || dcr_pkg::IDX_W != 6) begin : g_bad_w
      $error("Data, instruction and index widths do not match the ports");
   end
   if (dcr_pkg::PC_W != 23 || dcr_pkg::EXT_W != 24) begin : g_bad_a
      $error("Program counter and extended address widths do not match the ports");
   end

   logic [15:0] w_q [NBANK];
   logic [15:0] w_d [NBANK];
   logic [15:0] sp_q, sp_d;
   logic [15:0] sfr_q [dcr_pkg::SFR_N];
   logic [15:0] sfr_d [dcr_pkg::SFR_N];
   logic [2:0] ctx_q, ctx_d, mctx_q, mctx_d;
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic [15:0] rd_q, rd_d;
   logic [23:0] agaddr_q, agaddr_d;
   logic agpsv_q, agpsv_d, agdone_q, agdone_d, yerr_q, yerr_d, stk_q, stk_d;
   logic bus_wr, bus_req;
   logic [15:0] be_mask;
   logic [15:0] ea, nxt;
   logic [2:0] src_en;
   logic [5:0] src_idx [3];
   logic [15:0] src_dat [3];
   logic [15:0] src_msk [3];

   // Reads a working register of the active set; index fifteen is the stack pointer.
   function automatic logic [15:0] wread(input logic [3:0] i, input logic [2:0] c,
                                         input logic [15:0] w [NBANK], input logic [15:0] sp);
      int b;
      b = int'(c) * dcr_pkg::NW + int'(i);
      if (i == dcr_pkg::IX_SP[3:0]) return sp;
      return w[b];
   endfunction

   function automatic logic [14:0] rev15(input logic [14:0] v);
      logic [14:0] r;
      for (int k = 0; k < 15; k++) r[k] = v[14 - k];
      return r;
   endfunction

   // Maps an interrupt level onto the alternate set assigned to it, else the default set.
   function automatic logic [2:0] lvl_ctx(input logic [2:0] l, input logic [15:0] cfg);
      logic [2:0] c1, c2;
      c1 = cfg[dcr_pkg::ALT1_LSB +: 3];
      c2 = cfg[dcr_pkg::ALT2_LSB +: 3];
      if (l >= dcr_pkg::LVL_MIN && l <= dcr_pkg::LVL_MAX && l == c1) return 3'h1;
      if (l >= dcr_pkg::LVL_MIN && l <= dcr_pkg::LVL_MAX && l == c2) return 3'h2;
      return 3'h0;
   endfunction

   // Bus slave: one wait state, then the answer; unmapped words read zero.
   assign bus_req = AVS_READ | AVS_WRITE;
   assign bus_wr = AVS_WRITE & ~wait_q;
   assign be_mask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

   always_comb begin
      int s;
      s = int'(AVS_ADDRESS) - int'(dcr_pkg::IX_SFR0);
      wait_d = ~(bus_req & wait_q);
      rdata_d = rdata_q;
      if (AVS_READ & wait_q) begin
         rdata_d = 32'h0000_0000;
         if (AVS_ADDRESS <= dcr_pkg::IX_SP) begin
            rdata_d[15:0] = wread(AVS_ADDRESS[3:0], ctx_q, w_q, sp_q);
         end else if (AVS_ADDRESS < dcr_pkg::IX_CTX_STAT) begin
            rdata_d[15:0] = sfr_q[s];
         end else if (AVS_ADDRESS == dcr_pkg::IX_CTX_STAT) begin
            rdata_d[dcr_pkg::CTX_CUR_LSB +: 3] = ctx_q;
            rdata_d[2:0] = mctx_q;
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   // Address generators. Y is used only for the second operand of dual fetches.
   always_comb begin
      logic [15:0] st, en, len;
      logic [14:0] rv;
      logic [8:0] page;
      int mb;
      rv = 15'h0000;
      page = 9'h000;
      ea = wread(AG_REQ.ptr, ctx_q, w_q, sp_q);
      nxt = ea + AG_REQ.off;
      mb = AG_REQ.y_gen ? dcr_pkg::MOD_YEN : dcr_pkg::MOD_XEN;
      st = AG_REQ.y_gen ? sfr_q[dcr_pkg::S_YMOD_ST] : sfr_q[dcr_pkg::S_XMOD_ST];
      en = AG_REQ.y_gen ? sfr_q[dcr_pkg::S_YMOD_END] : sfr_q[dcr_pkg::S_XMOD_END];
      len = en - st + 16'h0002;
      if (!AG_REQ.y_gen && sfr_q[dcr_pkg::S_BREV_CTL][dcr_pkg::BREV_EN]
          && AG_REQ.ptr == sfr_q[dcr_pkg::S_MOD_CTL][dcr_pkg::MOD_XPTR_LSB +: 4]) begin
         rv = rev15(rev15(ea[15:1]) + rev15(sfr_q[dcr_pkg::S_BREV_CTL][14:0]));
         nxt = {rv, 1'b0};
      end else if (sfr_q[dcr_pkg::S_MOD_CTL][mb] && AG_REQ.ptr == (AG_REQ.y_gen
                   ? sfr_q[dcr_pkg::S_MOD_CTL][dcr_pkg::MOD_YPTR_LSB +: 4]
                   : sfr_q[dcr_pkg::S_MOD_CTL][dcr_pkg::MOD_XPTR_LSB +: 4])) begin
         if (nxt > en) nxt = nxt - len;
         else if (nxt < st) nxt = nxt + len;
      end
      page = AG_REQ.wr ? sfr_q[dcr_pkg::S_WR_PAGE][8:0] : sfr_q[dcr_pkg::S_RD_PAGE][8:0];
      agpsv_d = 1'b0;
      yerr_d = 1'b0;
      if (AG_REQ.y_gen) begin
         agaddr_d = {8'h00, ea};
         yerr_d = AG_REQ.valid & (ea < Y_BASE);
      end else if (!ea[15]) begin
         agaddr_d = {8'h00, ea};
      end else if (!AG_REQ.wr && sfr_q[dcr_pkg::S_RD_PAGE][dcr_pkg::PSV_BIT]) begin
         agaddr_d = {2'b00, page[7:0], ea[14:1]};
         agpsv_d = AG_REQ.valid;
      end else begin
         agaddr_d = {page, ea[14:0]};
      end
      agdone_d = AG_REQ.valid;
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         agaddr_q <= 24'h00_0000;
         agpsv_q <= 1'b0;
         agdone_q <= 1'b0;
         yerr_q <= 1'b0;
      end else begin
         agaddr_q <= agaddr_d;
         agpsv_q <= agpsv_d;
         agdone_q <= agdone_d;
         yerr_q <= yerr_d;
      end
   end

   // Register writes: core first, pointer update next, bus last so that the bus wins.
   always_comb begin
      src_en = {bus_wr, AG_REQ.valid, CORE_WR.valid};
      src_idx[0] = CORE_WR.idx;
      src_dat[0] = CORE_WR.data;
      src_msk[0] = 16'hffff;
      src_idx[1] = {2'b00, AG_REQ.ptr};
      src_dat[1] = nxt;
      src_msk[1] = 16'hffff;
      src_idx[2] = AVS_ADDRESS;
      src_dat[2] = AVS_WRITEDATA[15:0];
      src_msk[2] = be_mask;
   end

   always_comb begin
      int b, s;
      logic [15:0] m;
      w_d = w_q;
      sp_d = sp_q;
      sfr_d = sfr_q;
      b = 0;
      s = 0;
      m = 16'h0000;
      for (int k = 0; k < 3; k++) begin
         if (src_en[k]) begin
            if (src_idx[k] == dcr_pkg::IX_SP) begin
               sp_d = ((sp_d & ~src_msk[k]) | (src_dat[k] & src_msk[k])) & 16'hfffe;
            end else if (src_idx[k] < dcr_pkg::IX_SP) begin
               b = int'(ctx_q) * dcr_pkg::NW + int'(src_idx[k]);
               w_d[b] = (w_d[b] & ~src_msk[k]) | (src_dat[k] & src_msk[k]);
            end else if (src_idx[k] < dcr_pkg::IX_CTX_STAT) begin
               s = int'(src_idx[k]) - int'(dcr_pkg::IX_SFR0);
               m = src_msk[k] & dcr_pkg::SFR_MASK[s];
               sfr_d[s] = (sfr_d[s] & ~m) | (src_dat[k] & m);
            end
         end
      end
      if (LOOP_LOAD) begin
         sfr_d[dcr_pkg::S_LSTART_L] = {LOOP_START[15:1], 1'b0};
         sfr_d[dcr_pkg::S_LSTART_H] = {9'h000, LOOP_START[22:16]};
         sfr_d[dcr_pkg::S_LEND_L] = {LOOP_END[15:1], 1'b0};
         sfr_d[dcr_pkg::S_LEND_H] = {9'h000, LOOP_END[22:16]};
         sfr_d[dcr_pkg::S_LOOP_CNT] = LOOP_COUNT;
      end
      rd_d = wread(RD_SEL, ctx_q, w_q, sp_q);
      stk_d = sp_q > sfr_q[dcr_pkg::S_STK_LIM];
   end

   // Alternate sets are never cleared after reset, so a handler finds its values again.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         for (int i = 0; i < NBANK; i++) w_q[i] <= 16'h0000;
         for (int i = 0; i < dcr_pkg::SFR_N; i++) begin
            sfr_q[i] <= (i == dcr_pkg::S_CORE_CTL) ? dcr_pkg::CORE_CTL_RST : 16'h0000;
         end
         sp_q <= 16'h0000;
         rd_q <= 16'h0000;
         stk_q <= 1'b0;
      end else begin
         w_q <= w_d;
         sfr_q <= sfr_d;
         sp_q <= sp_d;
         rd_q <= rd_d;
         stk_q <= stk_d;
      end
   end

   // Context selection. An interrupt outranks a swap in the same cycle.
   always_comb begin
      ctx_d = ctx_q;
      mctx_d = mctx_q;
      if (SWAP_VALID && SWAP_CTX <= dcr_pkg::CTX_ALT2) begin
         ctx_d = SWAP_CTX;
         mctx_d = SWAP_CTX;
      end
      if (INT_TAKE) begin
         ctx_d = lvl_ctx(INT_LEVEL, sfr_q[dcr_pkg::S_ALT_CFG]);
      end else if (INT_RETURN) begin
         ctx_d = (INT_LEVEL == 3'h0) ? mctx_q : lvl_ctx(INT_LEVEL, sfr_q[dcr_pkg::S_ALT_CFG]);
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ctx_q <= dcr_pkg::CTX_DEF;
         mctx_q <= dcr_pkg::CTX_DEF;
      end else begin
         ctx_q <= ctx_d;
         mctx_q <= mctx_d;
      end
   end

   assign AVS_WAITREQUEST = wait_q;
   assign AVS_READDATA = rdata_q;
   assign RD_DATA = rd_q;
   assign CUR_CTX = ctx_q;
   assign AG_ADDR = agaddr_q;
   assign AG_PSV = agpsv_q;
   assign AG_YERR = yerr_q;
   assign AG_DONE = agdone_q;
   assign STK_ERR = stk_q;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_bus_req;
      (AVS_READ || AVS_WRITE) && wait_q;
   endsequence
   sequence s_bus_ack;
      !wait_q ##1 wait_q;
   endsequence

   a_bus_handshake: assert property (s_bus_req |=> s_bus_ack)
      else $error("bus request not answered after one wait state");
   a_bus_idle_wait: assert property (!(AVS_READ || AVS_WRITE) |=> wait_q)
      else $error("waitrequest low without a request");
   a_ctx_legal: assert property (ctx_q <= 3'h2 && mctx_q <= 3'h2)
      else $error("reserved context code in use");
   a_swap_ctx: assert property (SWAP_VALID && SWAP_CTX <= 3'h2
      && !INT_TAKE && !INT_RETURN |=> ctx_q == $past(SWAP_CTX) && mctx_q == $past(SWAP_CTX))
      else $error("swap did not select the requested set");
   a_swap_reserved: assert property (SWAP_VALID && SWAP_CTX > 3'h2
      && !INT_TAKE && !INT_RETURN |=> ctx_q == $past(ctx_q) && mctx_q == $past(mctx_q))
      else $error("reserved swap code changed the context");
   a_mctx_only_swap: assert property (mctx_q != $past(mctx_q) |-> $past(SWAP_VALID))
      else $error("manual context changed without a swap");
   a_ret_manual: assert property (INT_RETURN && !INT_TAKE && INT_LEVEL == 3'h0
      |=> ctx_q == $past(mctx_q))
      else $error("return to level zero did not restore the manual set");
   a_int_alt1: assert property (INT_TAKE && INT_LEVEL >= 3'h1 && INT_LEVEL <= 3'h6
      && INT_LEVEL == sfr_q[dcr_pkg::S_ALT_CFG][2:0] |=> ctx_q == 3'h1)
      else $error("assigned level did not select set one");
   a_int_alt2: assert property (INT_TAKE && INT_LEVEL >= 3'h1 && INT_LEVEL <= 3'h6
      && INT_LEVEL != sfr_q[dcr_pkg::S_ALT_CFG][2:0]
      && INT_LEVEL == sfr_q[dcr_pkg::S_ALT_CFG][6:4] |=> ctx_q == 3'h2)
      else $error("assigned level did not select set two");
   // Unassigned levels must fall back, or one handler would overwrite another level's set.
   a_int_default: assert property (INT_TAKE && (INT_LEVEL == 3'h0 || INT_LEVEL == 3'h7
      || (INT_LEVEL != sfr_q[dcr_pkg::S_ALT_CFG][2:0]
      && INT_LEVEL != sfr_q[dcr_pkg::S_ALT_CFG][6:4])) |=> ctx_q == 3'h0)
      else $error("unassigned level did not select the default set");
   a_lstart_ro: assert property (bus_wr && AVS_ADDRESS == 6'h1f && !LOOP_LOAD
      |=> $stable(sfr_q[dcr_pkg::S_LSTART_L]))
      else $error("loop start register changed on a write");
   a_loop_load: assert property (LOOP_LOAD
      |=> sfr_q[dcr_pkg::S_LOOP_CNT] == $past(LOOP_COUNT))
      else $error("loop count not loaded");
   a_sp_even: assert property (!sp_q[0])
      else $error("stack pointer lost its word alignment");
   a_rd_stack: assert property (RD_SEL == 4'hf |=> RD_DATA == $past(sp_q))
      else $error("index fifteen did not read the stack pointer");
   a_stk_over: assert property (sp_q > sfr_q[dcr_pkg::S_STK_LIM] |=> STK_ERR)
      else $error("stack overrun not flagged");
   a_stk_under: assert property (sp_q <= sfr_q[dcr_pkg::S_STK_LIM] |=> !STK_ERR)
      else $error("stack flag raised within the limit");
   a_rd_upper: assert property (AVS_READDATA[31:16] == 16'h0000)
      else $error("upper read half not zero");
   // A late answer would stall every instruction that forms an address.
   a_agu_done: assert property (AG_REQ.valid
      |=> AG_DONE ##1 (AG_DONE == $past(AG_REQ.valid)))
      else $error("address generator did not answer in one cycle");
   a_x_linear: assert property (AG_REQ.valid && !AG_REQ.y_gen && !ea[15]
      |=> AG_ADDR == {8'h00, $past(ea)} && !AG_PSV)
      else $error("base address not passed through unchanged");
   a_y_boundary: assert property (AG_REQ.valid && AG_REQ.y_gen
      |=> AG_YERR == ($past(ea) < Y_BASE))
      else $error("Y boundary flag wrong");
   a_ext_page: assert property (AG_REQ.valid && !AG_REQ.y_gen && ea[15]
      && (AG_REQ.wr || !sfr_q[dcr_pkg::S_RD_PAGE][dcr_pkg::PSV_BIT])
      |=> AG_ADDR[14:0] == $past(ea[14:0]) && !AG_PSV)
      else $error("extended address lost its base offset");
   a_psv_read: assert property (AG_REQ.valid && !AG_REQ.y_gen && ea[15] && !AG_REQ.wr
      && sfr_q[dcr_pkg::S_RD_PAGE][dcr_pkg::PSV_BIT]
      |=> AG_PSV && AG_ADDR[13:0] == $past(ea[14:1]))
      else $error("program window read not mapped");
   a_psv_upper: assert property (AG_PSV |-> $past(ea[15]) && !$past(AG_REQ.y_gen))
      else $error("program window used below the upper half");
endmodule

// *** dv/dcr_mem_model.sv ***
// Behavioural data and program memory on the far side of the address generators.
`timescale 1ns/1ps
module dcr_mem_model #(
   parameter int DEPTH = 256
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Address from the generators.
   input wire logic done,
   input wire logic [23:0] addr,
   input wire logic program_space_window,
   // Word returned one cycle after an access.
   output logic [23:0] rdata
);
   logic [23:0] prog_q [DEPTH];
   logic [15:0] data_q [DEPTH];
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         prog_q[i] = 24'(i * 3);
         data_q[i] = 16'(i * 5);
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 24'h000000;
      end else if (done) begin
         // Program words carry 24 bits; data words fill only the low 16.
         rdata <= program_space_window ? prog_q[addr[7:0]] : {8'h00, data_q[addr[8:1]]};
      end else begin
         // Nothing is valid between accesses, so the returned word keeps changing.
         rdata <= ~rdata;
      end
   end
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the working-register and address block.
`timescale 1ns/1ps
module tb;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic [5:0] AVS_ADDRESS = 6'h00;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic [3:0] AVS_BYTEENABLE = 4'h3;
   logic [31:0] AVS_READDATA;
   logic AVS_WAITREQUEST;
   dcr_pkg::dcr_core_wr_t CORE_WR = '0;
   logic [3:0] RD_SEL = 4'h0;
   logic [15:0] RD_DATA;
   logic INT_TAKE = 1'b0, INT_RETURN = 1'b0, SWAP_VALID = 1'b0, LOOP_LOAD = 1'b0;
   logic [2:0] INT_LEVEL = 3'h0, SWAP_CTX = 3'h0, CUR_CTX;
   logic [22:0] LOOP_START = 23'h0, LOOP_END = 23'h0;
   logic [15:0] LOOP_COUNT = 16'h0;
   dcr_pkg::dcr_agu_req_t AG_REQ = '0;
   logic [23:0] AG_ADDR, mem_word;
   logic AG_PSV, AG_YERR, AG_DONE, STK_ERR;
   // Expected read data, and expected address notes as {mask, address, psv, yerr}.
   logic [31:0] rdq[$];
   logic [49:0] agq[$];
   logic [49:0] ag_e;
   int error_cnt = 0;
   int n_tests = 0;
   int k;
   logic [15:0] v;
   always #4 CLK = ~CLK;
   dcr_regfile dut (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .CORE_WR(CORE_WR),
      .RD_SEL(RD_SEL), .RD_DATA(RD_DATA), .INT_TAKE(INT_TAKE), .INT_RETURN(INT_RETURN),
      .INT_LEVEL(INT_LEVEL), .SWAP_VALID(SWAP_VALID), .SWAP_CTX(SWAP_CTX), .CUR_CTX(CUR_CTX),
      .LOOP_LOAD(LOOP_LOAD), .LOOP_START(LOOP_START), .LOOP_END(LOOP_END),
      .LOOP_COUNT(LOOP_COUNT), .AG_REQ(AG_REQ), .AG_ADDR(AG_ADDR), .AG_PSV(AG_PSV),
      .AG_YERR(AG_YERR), .AG_DONE(AG_DONE), .STK_ERR(STK_ERR));
   dcr_mem_model mem (.clk(CLK), .rst(RST), .done(AG_DONE), .addr(AG_ADDR), .program_space_window(AG_PSV),
      .rdata(mem_word));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // The request stands until the edge that sees waitrequest low, and is released there.
   task automatic wait_ack();
      for (k = 0; k < 50; k++) begin
         @(posedge CLK);
         if (AVS_WAITREQUEST === 1'b0) break;
      end
      if (k < 50) begin
         AVS_READ <= 1'b0;
         AVS_WRITE <= 1'b0;
      end else begin
         error_cnt++;
         end_of_test();
      end
   endtask
   task automatic bus_wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= {16'h0000, d};
      AVS_WRITE <= 1'b1;
      wait_ack();
   endtask
   task automatic bus_rd(input logic [5:0] a, input logic [31:0] e);
      @(posedge CLK);
      rdq.push_back(e);
      AVS_ADDRESS <= a;
      AVS_READ <= 1'b1;
      wait_ack();
   endtask
   task automatic address_generator(input logic y, input logic [3:0] p, input logic [15:0] o,
                      input logic [49:0] e);
      @(posedge CLK);
      agq.push_back(e);
      AG_REQ <= '{valid: 1'b1, y_gen: y, wr: 1'b0, ptr: p, off: o};
      @(posedge CLK);
      AG_REQ <= '0;
      repeat (2) @(posedge CLK);
   endtask
   // Kind 0 takes an interrupt, 1 returns from one, 2 swaps by hand.
   task automatic ctx(input int kind, input logic [2:0] val, input logic [2:0] exp);
      @(posedge CLK);
      INT_LEVEL <= val;
      SWAP_CTX <= val;
      INT_TAKE <= (kind == 0);
      INT_RETURN <= (kind == 1);
      SWAP_VALID <= (kind == 2);
      @(posedge CLK);
      INT_TAKE <= 1'b0;
      INT_RETURN <= 1'b0;
      SWAP_VALID <= 1'b0;
      @(posedge CLK);
      check("cur_ctx", {29'h0, CUR_CTX}, {29'h0, exp});
   endtask
   // Results are compared against the oldest note when they appear.
   always @(posedge CLK) begin
      if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0 && rdq.size() > 0) begin
         check("readdata", AVS_READDATA, rdq.pop_front());
      end
      if (AG_DONE === 1'b1 && agq.size() > 0) begin
         ag_e = agq.pop_front();
         check("ag_addr", {8'h00, AG_ADDR & ag_e[49:26]}, {8'h00, ag_e[25:2]});
         check("ag_flags", {30'h0, AG_PSV, AG_YERR}, {30'h0, ag_e[1:0]});
      end
   end
   initial begin
      void'($urandom(43));
      repeat (8) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      check("reset_ctx", {29'h0, CUR_CTX}, 32'h0);
      bus_rd(6'h2c, 32'h0);
      bus_rd(6'h23, 32'h0020);
      bus_rd(6'h3f, 32'h0);
      v = 16'($urandom());
      bus_wr(6'h03, v);
      bus_rd(6'h03, {16'h0, v});
      bus_wr(6'h0f, 16'h0101);
      bus_rd(6'h0f, 32'h0100);
      RD_SEL <= 4'hf;
      repeat (2) @(posedge CLK);
      check("rd_data", {16'h0, RD_DATA}, 32'h0100);
      bus_wr(6'h19, 16'h00f0);
      repeat (3) @(posedge CLK);
      check("stk_err", {31'h0, STK_ERR}, 32'h1);
      bus_wr(6'h19, 16'h0200);
      repeat (3) @(posedge CLK);
      check("stk_err", {31'h0, STK_ERR}, 32'h0);
      // A low-lane write must keep the high byte of the stack pointer.
      AVS_BYTEENABLE <= 4'h1;
      bus_wr(6'h0f, 16'h00ff);
      AVS_BYTEENABLE <= 4'h3;
      bus_rd(6'h0f, 32'h01fe);
      LOOP_START <= 23'h123456;
      LOOP_END <= 23'h000100;
      LOOP_LOAD <= 1'b1;
      @(posedge CLK);
      LOOP_LOAD <= 1'b0;
      bus_wr(6'h1f, 16'hffff);
      bus_rd(6'h1f, 32'h3456);
      bus_rd(6'h20, 32'h0012);
      bus_rd(6'h21, 32'h0100);
      CORE_WR <= '{valid: 1'b1, idx: 6'h05, data: 16'h5a5a};
      @(posedge CLK);
      CORE_WR <= '0;
      bus_rd(6'h05, 32'h5a5a);
      // Set one answers level 3, set two level 5.
      bus_wr(6'h24, 16'h0053);
      bus_rd(6'h24, 32'h0053);
      ctx(0, 3'h3, 3'h1);
      bus_wr(6'h03, ~v);
      bus_rd(6'h03, {16'h0, ~v});
      ctx(0, 3'h5, 3'h2);
      bus_rd(6'h03, 32'h0);
      ctx(1, 3'h3, 3'h1);
      bus_rd(6'h03, {16'h0, ~v});
      ctx(1, 3'h0, 3'h0);
      bus_rd(6'h03, {16'h0, v});
      ctx(2, 3'h2, 3'h2);
      bus_rd(6'h2c, 32'h0202);
      ctx(2, 3'h5, 3'h2);
      ctx(2, 3'h1, 3'h1);
      bus_rd(6'h2c, 32'h0101);
      ctx(0, 3'h7, 3'h0);
      bus_rd(6'h2c, 32'h0001);
      ctx(2, 3'h0, 3'h0);
      bus_rd(6'h2c, 32'h0);
      // Paged access above the base space, then the program window.
      bus_wr(6'h1b, 16'h0012);
      v = 16'h8000 | (16'($urandom()) & 16'h3ffe);
      bus_wr(6'h02, v);
      address_generator(1'b0, 4'h2, 16'h0002, {24'hffffff, 9'h012, v[14:0], 2'b00});
      v = v + 16'h0002;
      bus_rd(6'h02, {16'h0, v});
      bus_wr(6'h1b, 16'h0203);
      address_generator(1'b0, 4'h2, 16'h0002, {24'hffffff, 2'b00, 8'h03, v[14:1], 2'b10});
      bus_wr(6'h04, 16'h0800);
      address_generator(1'b1, 4'h4, 16'h0000, {24'h007fff, 24'h000800, 2'b01});
      // Two-word circular buffer on pointer six wraps back to its start.
      bus_wr(6'h1b, 16'h0000);
      bus_wr(6'h25, 16'h8000);
      bus_wr(6'h26, 16'h8002);
      bus_wr(6'h29, 16'h8006);
      bus_wr(6'h06, 16'h8002);
      address_generator(1'b0, 4'h6, 16'h0002, {24'hffffff, 24'h000002, 2'b00});
      bus_rd(6'h06, 32'h8000);
      // Bit-reversed stepping on pointer six: word indices 0, 8, 4.
      bus_wr(6'h2a, 16'h8008);
      bus_wr(6'h06, 16'h0000);
      address_generator(1'b0, 4'h6, 16'h0002, {24'hffffff, 24'h000000, 2'b00});
      bus_rd(6'h06, 32'h0010);
      address_generator(1'b0, 4'h6, 16'h0002, {24'hffffff, 24'h000010, 2'b00});
      bus_rd(6'h06, 32'h0008);
      repeat (4) @(posedge CLK);
      check("queues_empty", rdq.size() + agq.size(), 32'h0);
      end_of_test();
   end
endmodule
